//--- core/wrc_top.sv
// Watchdog timer and reset control with AHB-Lite register access
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module wrc_top
	import wrc_pkg::*;
#(
	parameter int SOFT_DELAY_TICKS = wrc_pkg::WRC_SOFT_DELAY_TICKS,
	parameter int FILTER_TICKS = wrc_pkg::WRC_FILTER_TICKS
) (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic SLOW_OSC_CLK,
	input wire logic LOW_SUPPLY,
	input wire logic LOW_POWER_MODE,
	input wire logic WDT_CLEAR_INSTR,
	input wire logic HALT_INSTR,
	output logic DEVICE_RESET,
	output logic PC_SP_RESET,
	output logic TIMEOUT_FLAG,
	output logic POR_INIT,
	output logic IRQ
);
	import wrc_pkg::*;

	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------

	// Enable key is one of its two legal codes
	function automatic logic key_valid(input logic [4:0] key);
		key_valid = (key == WRC_KEY_ENABLE) || (key == WRC_KEY_DISABLE);
	endfunction : key_valid

	// Guard key is one of its two legal codes
	function automatic logic guard_valid(input logic [7:0] key);
		guard_valid = (key == WRC_GUARD_OK_A) || (key == WRC_GUARD_OK_B);
	endfunction : guard_valid

	// Threshold code is one of the four legal codes
	function automatic logic level_valid(input logic [7:0] code);
		level_valid = (code == WRC_LEVEL_A) || (code == WRC_LEVEL_B) ||
			(code == WRC_LEVEL_C) || (code == WRC_LEVEL_D);
	endfunction : level_valid

	// Terminal count for a period code: 2^n slow cycles, minus one
	function automatic logic [WRC_WDT_WIDTH-1:0] period_limit(input logic [2:0] sel);
		logic [4:0] shift;
		shift = 5'h08;
		case (sel)
			3'h0: shift = 5'h08;
			3'h1: shift = 5'h0a;
			3'h2: shift = 5'h0c;
			3'h3: shift = 5'h0e;
			3'h4: shift = 5'h0f;
			3'h5: shift = 5'h10;
			3'h6: shift = 5'h11;
			3'h7: shift = 5'h12;
			default: shift = 5'h08;
		endcase
		period_limit = WRC_WDT_WIDTH'((19'h00001 << shift) - 19'h00001);
	endfunction : period_limit

	// ----------------------------------------
	// Delay counts, in slow oscillator cycles
	// ----------------------------------------
	localparam logic [WRC_DELAY_WIDTH-1:0] SOFT_LIMIT =
		WRC_DELAY_WIDTH'(SOFT_DELAY_TICKS - 1);
	localparam logic [WRC_DELAY_WIDTH-1:0] FILTER_LIMIT =
		WRC_DELAY_WIDTH'(FILTER_TICKS - 1);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0] wdt_ctrl; // watchdog_control
	logic [7:0] guard_key; // reset_guard_key
	logic [7:0] level_ctrl; // brownout_level_control
	logic [3:0] cause; // Implemented bits of reset_cause_flags
	logic [WRC_EV_BITS-1:0] irq_stat; // Sticky events
	logic [WRC_EV_BITS-1:0] irq_mask; // Event enables
	logic [7:0] next_wdt_ctrl;
	logic [7:0] next_guard_key;
	logic [7:0] next_level_ctrl;
	logic [3:0] next_cause;
	logic [WRC_EV_BITS-1:0] next_irq_stat;
	logic [WRC_EV_BITS-1:0] next_irq_mask;
	wrc_addr_phase_t aph; // Captured address phase
	wrc_addr_phase_t next_aph;
	logic [31:0] next_hrdata;
	logic next_device_reset;
	logic next_pc_sp_reset;
	logic next_timeout_flag;
	logic next_irq;
	logic [1:0] sync_in; // Synchronised oscillator and supply levels
	logic osc_prev; // Oscillator level one cycle ago
	logic slow_tick; // One cycle per slow oscillator rise
	logic wdt_run; // Watchdog enabled by its key
	logic wdt_overflow; // Watchdog terminal count reached
	logic soft_done; // Soft-reset delay elapsed
	logic filter_done; // Low supply outlasted the filter time
	logic low_v_watch; // Low supply seen while the check is active
	wrc_fault_t fault; // Faults waiting on the soft-reset delay
	logic addr_go; // Address phase accepted this cycle
	logic [3:0] cause_set; // Hardware sets of the cause flags
	logic [WRC_EV_BITS-1:0] ev; // Events this cycle

	// ----------------------------------------
	// Slow oscillator and supply input
	// ----------------------------------------

	// Both pins come from outside the MCLK domain
	wrc_sync #(
		.WIDTH(2)
	) u_sync (
		.clk(MCLK),
		.rst_n(RESET_N),
		.async_in({LOW_SUPPLY, SLOW_OSC_CLK}),
		.sync_out(sync_in)
	);

	// Edge memory for the synchronised oscillator
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			osc_prev <= 1'b0;
		end
		else
		begin
			osc_prev <= sync_in[0];
		end
	end

	// The oscillator is far slower than MCLK, so one rise makes one tick
	assign slow_tick = sync_in[0] && !osc_prev;

	// ----------------------------------------
	// Watchdog counter
	// ----------------------------------------
	assign wdt_run = (wdt_ctrl[7:WRC_KEY_LSB] == WRC_KEY_ENABLE);

	// Disabled counter is held at zero; instructions and resets clear it
	wrc_tick_counter #(
		.WIDTH(WRC_WDT_WIDTH)
	) u_wdt (
		.clk(MCLK),
		.rst_n(RESET_N),
		.run(wdt_run),
		.clear(WDT_CLEAR_INSTR || HALT_INSTR || DEVICE_RESET),
		.tick(slow_tick),
		.limit(period_limit(wdt_ctrl[WRC_SEL_LSB +: 3])),
		.done(wdt_overflow)
	);

	// ----------------------------------------
	// Soft-reset delay and brownout filter
	// ----------------------------------------
	assign fault.key = !key_valid(wdt_ctrl[7:WRC_KEY_LSB]);
	assign fault.guard = !guard_valid(guard_key);
	assign fault.thresh = !level_valid(level_ctrl);

	// Runs while any bad code stands; the device reset restores the codes
	wrc_tick_counter #(
		.WIDTH(WRC_DELAY_WIDTH)
	) u_soft (
		.clk(MCLK),
		.rst_n(RESET_N),
		.run(|fault),
		.clear(DEVICE_RESET),
		.tick(slow_tick),
		.limit(SOFT_LIMIT),
		.done(soft_done)
	);

	// Low-voltage check is masked in idle and sleep
	assign low_v_watch = sync_in[1] && !LOW_POWER_MODE;

	// A short dip drops run and restarts the filter from zero
	wrc_tick_counter #(
		.WIDTH(WRC_DELAY_WIDTH)
	) u_filter (
		.clk(MCLK),
		.rst_n(RESET_N),
		.run(low_v_watch),
		.clear(DEVICE_RESET),
		.tick(slow_tick),
		.limit(FILTER_LIMIT),
		.done(filter_done)
	);

	// ----------------------------------------
	// Event decode
	// ----------------------------------------
	always_comb
	begin
		cause_set = 4'h0;
		cause_set[WRC_CF_WDT_KEY] = soft_done && fault.key;
		cause_set[WRC_CF_THRESH] = soft_done && fault.thresh;
		cause_set[WRC_CF_LOW_V] = filter_done;
		cause_set[WRC_CF_GUARD] = soft_done && fault.guard;
		ev = {wdt_overflow, cause_set};
	end

	// ----------------------------------------
	// Bus address phase
	// ----------------------------------------
	assign addr_go = HSEL && HREADY && (HTRANS == WRC_HTRANS_NONSEQ ||
		HTRANS == WRC_HTRANS_SEQ);

	// Capture the write target; read data is fetched at once
	always_comb
	begin
		next_aph.write = addr_go && HWRITE;
		next_aph.addr = addr_go ? HADDR[7:0] : aph.addr;
		next_hrdata = HRDATA;
		if (addr_go && !HWRITE)
		begin
			case (HADDR[7:0])
				WRC_OFS_WDT_CTRL: next_hrdata = {24'h000000, wdt_ctrl};
				WRC_OFS_CAUSE: next_hrdata = {28'h0000000, cause};
				WRC_OFS_GUARD: next_hrdata = {24'h000000, guard_key};
				WRC_OFS_LEVEL: next_hrdata = {24'h000000, level_ctrl};
				WRC_OFS_IRQ_STAT: next_hrdata = {27'h0000000, irq_stat};
				WRC_OFS_IRQ_MASK: next_hrdata = {27'h0000000, irq_mask};
				WRC_OFS_STATUS: next_hrdata = {30'h00000000, wdt_run, TIMEOUT_FLAG};
				default: next_hrdata = 32'h00000000; // Unmapped reads zero
			endcase
		end
	end

	// Bus-side registers; the slave never waits and never errors
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			aph <= '0;
			HRDATA <= 32'h00000000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
		else
		begin
			aph <= next_aph;
			HRDATA <= next_hrdata;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	// ----------------------------------------
	// Control registers and flags
	// ----------------------------------------

	// Writes land in the data phase; hardware sets win over software clears
	always_comb
	begin
		next_wdt_ctrl = wdt_ctrl;
		next_guard_key = guard_key;
		next_level_ctrl = level_ctrl;
		next_irq_mask = irq_mask;
		next_cause = cause;
		next_irq_stat = irq_stat;
		if (aph.write)
		begin
			case (aph.addr)
				WRC_OFS_WDT_CTRL: next_wdt_ctrl = HWDATA[7:0];
				WRC_OFS_GUARD: next_guard_key = HWDATA[7:0];
				WRC_OFS_LEVEL: next_level_ctrl = HWDATA[7:0];
				WRC_OFS_IRQ_MASK: next_irq_mask = HWDATA[WRC_EV_BITS-1:0];
				// A zero clears a cause flag, a one leaves it alone; a one clears an event bit
				WRC_OFS_CAUSE: next_cause = cause & HWDATA[3:0];
				WRC_OFS_IRQ_STAT: next_irq_stat = irq_stat & ~HWDATA[WRC_EV_BITS-1:0];
				default: next_cause = cause; // Unmapped writes are dropped
			endcase
		end
		// A device reset restores the keys and the threshold code
		if (DEVICE_RESET)
		begin
			next_wdt_ctrl = WRC_RST_WDT_CTRL;
			next_guard_key = WRC_RST_GUARD;
			next_level_ctrl = WRC_RST_LEVEL;
		end
		next_cause = next_cause | cause_set;
		next_irq_stat = next_irq_stat | ev;
	end

	// Power-on values; the low-voltage flag starts clear here
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			wdt_ctrl <= WRC_RST_WDT_CTRL;
			guard_key <= WRC_RST_GUARD;
			level_ctrl <= WRC_RST_LEVEL;
			cause <= 4'h0;
			irq_stat <= '0;
			irq_mask <= '0;
		end
		else
		begin
			wdt_ctrl <= next_wdt_ctrl;
			guard_key <= next_guard_key;
			level_ctrl <= next_level_ctrl;
			cause <= next_cause;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
		end
	end

	// ----------------------------------------
	// Reset and status outputs
	// ----------------------------------------

	// Timeout resets the device when running, only PC/SP when asleep
	always_comb
	begin
		next_device_reset = soft_done || filter_done;
		next_pc_sp_reset = 1'b0;
		next_timeout_flag = TIMEOUT_FLAG;
		if (WDT_CLEAR_INSTR || HALT_INSTR)
		begin
			next_timeout_flag = 1'b0; // Entering halt or clearing drops it
		end
		if (wdt_overflow)
		begin
			next_timeout_flag = 1'b1;
			if (LOW_POWER_MODE)
			begin
				next_pc_sp_reset = 1'b1;
			end
			else
			begin
				next_device_reset = 1'b1;
			end
		end
		next_irq = |(next_irq_stat & next_irq_mask);
	end

	// POR_INIT asks the core to zero the PC and set port registers high
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			DEVICE_RESET <= 1'b0;
			PC_SP_RESET <= 1'b0;
			TIMEOUT_FLAG <= 1'b0;
			POR_INIT <= 1'b1;
			IRQ <= 1'b0;
		end
		else
		begin
			DEVICE_RESET <= next_device_reset;
			PC_SP_RESET <= next_pc_sp_reset;
			TIMEOUT_FLAG <= next_timeout_flag;
			POR_INIT <= 1'b0;
			IRQ <= next_irq;
		end
	end
endmodule : wrc_top
`default_nettype wire

//--- include/wrc_pkg.sv
// Package with register map, field layout, codes and timing for the watchdog/reset block
package wrc_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] WRC_OFS_WDT_CTRL = 8'h00; // watchdog_control
	localparam logic [7:0] WRC_OFS_CAUSE = 8'h04; // reset_cause_flags
	localparam logic [7:0] WRC_OFS_GUARD = 8'h08; // reset_guard_key
	localparam logic [7:0] WRC_OFS_LEVEL = 8'h0c; // brownout_level_control
	localparam logic [7:0] WRC_OFS_IRQ_STAT = 8'h10; // Sticky event bits, write one to clear
	localparam logic [7:0] WRC_OFS_IRQ_MASK = 8'h14; // Event enables
	localparam logic [7:0] WRC_OFS_STATUS = 8'h18; // Read-only block state

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] WRC_RST_WDT_CTRL = 8'h53;
	localparam logic [7:0] WRC_RST_GUARD = 8'h55;
	localparam logic [7:0] WRC_RST_LEVEL = 8'h55;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int WRC_KEY_LSB = 3; // wdt_enable_key is bits 7..3
	localparam int WRC_SEL_LSB = 0; // wdt_period_select is bits 2..0
	localparam int WRC_CF_WDT_KEY = 0; // wdt_key_fault_flag
	localparam int WRC_CF_THRESH = 1; // threshold_select_fault_flag
	localparam int WRC_CF_LOW_V = 2; // low_voltage_reset_flag
	localparam int WRC_CF_GUARD = 3; // guard_key_fault_flag
	localparam int WRC_EV_TIMEOUT = 4; // Event bit for a watchdog overflow
	localparam int WRC_EV_BITS = 5; // Number of event bits
	localparam int WRC_ST_TIMEOUT = 0; // timeout_flag in the status word
	localparam int WRC_ST_WDT_RUN = 1; // Watchdog running in the status word

	// ----------------------------------------
	// Key and threshold codes
	// ----------------------------------------
	localparam logic [4:0] WRC_KEY_DISABLE = 5'h15; // 10101B
	localparam logic [4:0] WRC_KEY_ENABLE = 5'h0a; // 01010B
	localparam logic [7:0] WRC_GUARD_OK_A = 8'h55; // 01010101B
	localparam logic [7:0] WRC_GUARD_OK_B = 8'haa; // 10101010B
	localparam logic [7:0] WRC_LEVEL_A = 8'h55; // 01010101
	localparam logic [7:0] WRC_LEVEL_B = 8'h33; // 00110011
	localparam logic [7:0] WRC_LEVEL_C = 8'h99; // 10011001
	localparam logic [7:0] WRC_LEVEL_D = 8'haa; // 10101010

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int WRC_MCLK_HZ = 50000000; // System clock rate
	localparam int WRC_SLOW_OSC_HZ = 32000; // Nominal slow oscillator rate
	localparam int WRC_WDT_WIDTH = 18; // Longest period is 2^18 slow cycles
	localparam int WRC_SOFT_DELAY_TICKS = 4; // Soft-reset delay, slow cycles
	localparam int WRC_FILTER_TICKS = 4; // Brownout filter time, slow cycles
	localparam int WRC_DELAY_WIDTH = 16; // Width of delay counters

	// ----------------------------------------
	// Bus transfer codes
	// ----------------------------------------
	localparam logic [1:0] WRC_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] WRC_HTRANS_SEQ = 2'h3;

	// Address phase captured for the data phase
	typedef struct packed {
		logic write; // Write pending
		logic [7:0] addr; // Low address bits
	} wrc_addr_phase_t;

	// Faults that request a delayed device reset
	typedef struct packed {
		logic guard; // Guard key invalid
		logic thresh; // Threshold code invalid
		logic key; // Enable key invalid
	} wrc_fault_t;

endpackage : wrc_pkg

//--- core/wrc_sync.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ns
`default_nettype none
module wrc_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// ----------------------------------------
	// Stages
	// ----------------------------------------
	logic [WIDTH-1:0] stage1; // Metastable stage, read only by stage two

	// Both stages clear under reset; inputs are only sampled afterwards
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1 <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : wrc_sync
`default_nettype wire

//--- core/wrc_tick_counter.sv
// Tick counter that pulses done when it has counted limit+1 ticks
`timescale 1ns/1ns
`default_nettype none
module wrc_tick_counter #(
	parameter int WIDTH = 18
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic clear,
	input wire logic tick,
	input wire logic [WIDTH-1:0] limit,
	output logic done
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [WIDTH-1:0] count; // Ticks seen so far
	logic [WIDTH-1:0] next_count;
	logic next_done;

	// Next count; a stopped or cleared counter rests at zero
	always_comb
	begin
		next_count = count;
		next_done = 1'b0;
		if (clear || !run)
		begin
			next_count = '0;
		end
		else if (tick)
		begin
			if (count >= limit)
			begin
				next_count = '0; // Wrap and report
				next_done = 1'b1;
			end
			else
			begin
				next_count = count + 1'b1;
			end
		end
	end

	// Register the count and the done pulse
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count <= '0;
			done <= 1'b0;
		end
		else
		begin
			count <= next_count;
			done <= next_done;
		end
	end
endmodule : wrc_tick_counter
`default_nettype wire

//--- verification/wrc_top_asserts.sv
// Port-level checker for the watchdog and reset controller
`timescale 1ns/1ns
`default_nettype none
module wrc_top_asserts #(
	parameter int SOFT_DELAY_TICKS = 4,
	parameter int FILTER_TICKS = 4
) (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic HSEL,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic LOW_POWER_MODE,
	input wire logic WDT_CLEAR_INSTR,
	input wire logic HALT_INSTR,
	input wire logic DEVICE_RESET,
	input wire logic PC_SP_RESET,
	input wire logic TIMEOUT_FLAG,
	input wire logic POR_INIT,
	input wire logic IRQ
);
	// ----------------------------------------
	// Shared clock and reset
	// ----------------------------------------
	default clocking dclk @(posedge MCLK);
	endclocking
	default disable iff (!RESET_N);

	// Read request accepted on this edge
	logic rd_taken;
	assign rd_taken = HSEL && HREADY && HTRANS[1] && !HWRITE;

	// ----------------------------------------
	// Bus behaviour
	// ----------------------------------------
	ready_high_a: assert property (HREADYOUT == 1'b1)
		else $error("slave inserted a wait state");
	okay_resp_a: assert property (HRESP == 1'b0)
		else $error("slave answered with an error");
	rdata_hold_a: assert property (!rd_taken |=> $stable(HRDATA))
		else $error("read data moved without a read");
	rdata_narrow_a: assert property (HRDATA[31:8] == 24'h0)
		else $error("unused read data bits are set");

	// ----------------------------------------
	// Reset outputs and time-out flag
	// ----------------------------------------
	por_once_a: assert property (POR_INIT |=> !POR_INIT)
		else $error("power-on init lasted past release");
	rst_pulse_a: assert property (DEVICE_RESET |=> !DEVICE_RESET)
		else $error("device reset longer than one cycle");
	pcsp_sleep_a: assert property (PC_SP_RESET |-> TIMEOUT_FLAG && !DEVICE_RESET && $past(LOW_POWER_MODE))
		else $error("partial reset outside low power");
	to_mode_a: assert property ($rose(TIMEOUT_FLAG) |-> (DEVICE_RESET == !$past(LOW_POWER_MODE)))
		else $error("time-out raised with wrong reset kind");
	to_sticky_a: assert property (TIMEOUT_FLAG && !WDT_CLEAR_INSTR && !HALT_INSTR |=> TIMEOUT_FLAG)
		else $error("time-out flag dropped by itself");
	to_clear_a: assert property ((WDT_CLEAR_INSTR || HALT_INSTR) |=> !TIMEOUT_FLAG || DEVICE_RESET || PC_SP_RESET)
		else $error("clear instruction kept time-out flag");

	// Main scenarios reached
	cover property (DEVICE_RESET);
	cover property (PC_SP_RESET);
	cover property (IRQ);
endmodule : wrc_top_asserts

bind wrc_top wrc_top_asserts #(.SOFT_DELAY_TICKS(SOFT_DELAY_TICKS), .FILTER_TICKS(FILTER_TICKS)) u_chk (
	.MCLK(MCLK), .RESET_N(RESET_N), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
	.HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
	.LOW_POWER_MODE(LOW_POWER_MODE), .WDT_CLEAR_INSTR(WDT_CLEAR_INSTR), .HALT_INSTR(HALT_INSTR),
	.DEVICE_RESET(DEVICE_RESET), .PC_SP_RESET(PC_SP_RESET), .TIMEOUT_FLAG(TIMEOUT_FLAG),
	.POR_INIT(POR_INIT), .IRQ(IRQ)
);
`default_nettype wire

//--- verification/wrc_tb.sv
// Self-checking bench for the watchdog and reset controller
`timescale 1ns/1ns
`default_nettype none
module tb;
	import wrc_pkg::*;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic mclk, rst_n, hsel, hwrite, slow, low_sup, lpm, wdt_clear, halt_instr;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, div;
	logic hreadyout, hresp, device_reset, pc_sp_reset, timeout_flag, por_init, irq;
	int bad_count, samples_checked, cycles;

	wrc_top #(.SOFT_DELAY_TICKS(4), .FILTER_TICKS(4)) dut (
		.MCLK(mclk), .RESET_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .SLOW_OSC_CLK(slow),
		.LOW_SUPPLY(low_sup), .LOW_POWER_MODE(lpm), .WDT_CLEAR_INSTR(wdt_clear),
		.HALT_INSTR(halt_instr), .DEVICE_RESET(device_reset), .PC_SP_RESET(pc_sp_reset),
		.TIMEOUT_FLAG(timeout_flag), .POR_INIT(por_init), .IRQ(irq)
	);

	// 20 ns system clock
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// Slow oscillator: one tick per 8 system cycles keeps runs short
	always @(posedge mclk)
	begin
		div <= div + 2'h1;
		if (div == 2'h3)
			slow <= ~slow;
	end

	// Hang guard, well above the longest scenario
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 45000)
		begin
			bad_count++;
			end_of_test();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic end_of_test;
		if (bad_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask : check

	// One single AHB-Lite transfer; waits on ready, never assumes latency
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= WRC_HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr

	task automatic ck_rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		check($sformatf("reg %h", a), e, x);
	endtask : ck_rd

	// Waits for a reset pulse; n reaches lim when none came
	task automatic wait_pulse(input logic pcsp, input int lim, output int n);
		n = 0;
		do
		begin
			@(posedge mclk);
			#1;
			n++;
		end while (((pcsp ? pc_sp_reset : device_reset) !== 1'b1) && n < lim);
	endtask : wait_pulse

	// One-cycle clear or halt instruction
	task automatic pulse(input logic h);
		@(posedge mclk);
		halt_instr <= h;
		wdt_clear <= !h;
		@(posedge mclk);
		halt_instr <= 1'b0;
		wdt_clear <= 1'b0;
		#1;
	endtask : pulse

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic s_regs;
		logic [7:0] ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
		logic [31:0] exp [8] = '{32'h53, 32'h0, 32'h55, 32'h55, 32'h0, 32'h0, 32'h2, 32'h0};
		wr(8'h1c, 32'hff);
		wr(WRC_OFS_CAUSE, 32'hff);
		wr(WRC_OFS_STATUS, 32'h0);
		for (int i = 0; i < 8; i++)
			ck_rd(ofs[i], exp[i]);
	endtask : s_regs

	task automatic s_period;
		int n;
		int t;
		wr(WRC_OFS_IRQ_MASK, 32'h10);
		for (int s = 0; s < 2; s++)
		begin
			t = 8 << (8 + 2 * s);
			wr(WRC_OFS_WDT_CTRL, {24'h0, WRC_KEY_DISABLE, 3'h0});
			wr(WRC_OFS_WDT_CTRL, {24'h0, WRC_KEY_ENABLE, 3'(s)});
			wait_pulse(1'b0, 9000, n);
			check("wdt period", 32'h1, 32'(n > t - 12 && n < t + 12));
			check("timeout flag", 32'h1, 32'(timeout_flag));
			ck_rd(WRC_OFS_IRQ_STAT, 32'h10);
			check("irq", 32'h1, 32'(irq));
			ck_rd(WRC_OFS_WDT_CTRL, 32'h53);
			wr(WRC_OFS_IRQ_STAT, 32'h10);
			pulse(1'b0);
			check("irq cleared", 32'h0, 32'(irq));
			check("timeout cleared", 32'h0, 32'(timeout_flag));
		end
	endtask : s_period

	task automatic s_clear;
		int n;
		wr(WRC_OFS_WDT_CTRL, {24'h0, WRC_KEY_ENABLE, 3'h0});
		for (int i = 0; i < 3; i++)
		begin
			wait_pulse(1'b0, 1600, n);
			check("no overflow", 32'd1600, 32'(n));
			pulse(i == 2);
		end
		wr(WRC_OFS_WDT_CTRL, {24'h0, WRC_KEY_DISABLE, 3'h0});
		wait_pulse(1'b0, 2400, n);
		check("disabled", 32'd2400, 32'(n));
		ck_rd(WRC_OFS_STATUS, 32'h0);
	endtask : s_clear

	task automatic s_sleep;
		int n;
		@(posedge mclk);
		lpm <= 1'b1;
		wr(WRC_OFS_WDT_CTRL, {24'h0, WRC_KEY_ENABLE, 3'h0});
		wait_pulse(1'b1, 2200, n);
		check("sleep overflow", 32'h1, 32'(n < 2200));
		ck_rd(WRC_OFS_WDT_CTRL, {24'h0, WRC_KEY_ENABLE, 3'h0});
		ck_rd(WRC_OFS_STATUS, 32'h3);
		wr(WRC_OFS_WDT_CTRL, {24'h0, WRC_KEY_DISABLE, 3'h0});
		lpm <= 1'b0;
		pulse(1'b1);
		wr(WRC_OFS_IRQ_STAT, 32'h1f);
	endtask : s_sleep

	task automatic s_faults;
		logic [7:0] fa [3] = '{WRC_OFS_WDT_CTRL, WRC_OFS_GUARD, WRC_OFS_LEVEL};
		logic [31:0] rv [3] = '{32'h53, 32'h55, 32'h55};
		int fb [3] = '{WRC_CF_WDT_KEY, WRC_CF_GUARD, WRC_CF_THRESH};
		logic [7:0] va [4] = '{WRC_OFS_GUARD, WRC_OFS_LEVEL, WRC_OFS_LEVEL, WRC_OFS_LEVEL};
		logic [7:0] vv [4] = '{8'haa, 8'h33, 8'h99, 8'haa};
		logic [31:0] e;
		int n;
		e = 32'h0;
		for (int i = 0; i < 3; i++)
		begin
			wr(fa[i], 32'h12);
			wait_pulse(1'b0, 300, n);
			check("fault reset", 32'h1, 32'(n < 300));
			e = e | (32'h1 << fb[i]);
			ck_rd(WRC_OFS_CAUSE, e);
			ck_rd(fa[i], rv[i]);
		end
		check("irq masked", 32'h0, 32'(irq));
		wr(WRC_OFS_IRQ_MASK, 32'h0f);
		// IRQ is relaunched on the edge that ends the mask write; look after it settles
		#1;
		check("irq unmasked", 32'h1, 32'(irq));
		wr(WRC_OFS_IRQ_STAT, 32'h0f);
		ck_rd(WRC_OFS_IRQ_STAT, 32'h0);
		wr(WRC_OFS_CAUSE, 32'h0e);
		ck_rd(WRC_OFS_CAUSE, e & 32'h0e);
		wr(WRC_OFS_CAUSE, 32'h0);
		ck_rd(WRC_OFS_CAUSE, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			wr(va[i], {24'h0, vv[i]});
			wait_pulse(1'b0, 100, n);
			check("valid code", 32'd100, 32'(n));
			ck_rd(va[i], {24'h0, vv[i]});
		end
	endtask : s_faults

	task automatic s_lowv;
		int n;
		@(posedge mclk);
		low_sup <= 1'b1;
		repeat (16) @(posedge mclk);
		low_sup <= 1'b0;
		wait_pulse(1'b0, 100, n);
		check("short dip", 32'd100, 32'(n));
		@(posedge mclk);
		lpm <= 1'b1;
		low_sup <= 1'b1;
		wait_pulse(1'b0, 100, n);
		check("asleep dip", 32'd100, 32'(n));
		@(posedge mclk);
		lpm <= 1'b0;
		wait_pulse(1'b0, 100, n);
		low_sup <= 1'b0;
		check("long dip", 32'h1, 32'(n < 100));
		ck_rd(WRC_OFS_CAUSE, 32'h1 << WRC_CF_LOW_V);
		ck_rd(WRC_OFS_IRQ_STAT, 32'h1 << WRC_CF_LOW_V);
	endtask : s_lowv

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{rst_n, hsel, hwrite, slow, low_sup, lpm, wdt_clear, halt_instr} = 8'h0;
		{haddr, hwdata, htrans, div} = '0;
		{bad_count, samples_checked, cycles} = '0;
		repeat (10) @(posedge mclk);
		check("por during reset", 32'h1, 32'(por_init));
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		check("por after release", 32'h0, 32'(por_init));
		s_regs();
		s_period();
		s_clear();
		s_sleep();
		s_faults();
		s_lowv();
		end_of_test();
	end
endmodule : tb
`default_nettype wire
